// ==== rtl/gnss_pss_pkg.sv ====
// shared constants, states and carriers of the power-save sequencer
// assumes a 25 MHz ref_clk and a host that drives config and wake pins
package gnss_pss_pkg;
	// clock and time base
	localparam int CLK_HZ        = 25000000;
	localparam int MS_PER_S      = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

	// intervals above one week of milliseconds are refused
	localparam logic [31:0] WEEK_MS = 32'h240c8400;

	// no-signal give-up time, printed in seconds
	localparam int          NO_SIGNAL_S  = 15;
	localparam logic [31:0] NO_SIGNAL_MS = 32'(NO_SIGNAL_S * MS_PER_S);

	// orbit data download grid, printed in minutes
	localparam int          ORBIT_GRID_MIN = 30;
	localparam logic [31:0] ORBIT_GRID_MS  =
		32'(ORBIT_GRID_MIN * 60 * MS_PER_S);

	// least extra acquisition time when holding for a time fix
	localparam int          TIME_FIX_EXTRA_S  = 2;
	localparam logic [31:0] TIME_FIX_EXTRA_MS =
		32'(TIME_FIX_EXTRA_S * MS_PER_S);

	// search limit used when the host leaves the maximum at zero
	localparam logic [31:0] AUTO_MAX_SEARCH_MS = 32'h0000ea60;

	// configuration reset values
	localparam logic [31:0] RST_FIX_INTERVAL   = 32'h00000000;
	localparam logic [31:0] RST_RETRY_INTERVAL = 32'h00000000;
	localparam logic [31:0] RST_MIN_SEARCH     = 32'h00000000;
	localparam logic [31:0] RST_MAX_SEARCH     = 32'h00000000;
	localparam logic [31:0] RST_HOLD_TIME      = 32'h00000000;

	typedef enum logic [2:0] {
		ST_ACQUIRE     = 3'h0,
		ST_TRACK       = 3'h1,
		ST_POT         = 3'h3,
		ST_WAIT_FIX    = 3'h2,
		ST_WAIT_SEARCH = 3'h6
	} seq_state_e;

	typedef enum logic [1:0] {
		MODE_CONTINUOUS = 2'h0,
		MODE_CYCLIC     = 2'h1,
		MODE_ON_OFF     = 2'h2
	} operating_mode_e;

	// host configuration, all times in milliseconds
	typedef struct packed {
		operating_mode_e operatingModeSelect;
		logic [31:0]     fixInterval;
		logic [31:0]     retryInterval;
		logic [31:0]     minSearchTime;
		logic [31:0]     maxSearchTime;
		logic [31:0]     trackingHoldTime;
		logic            holdForTimeFix;
		logic            stayAwakeOnNoFix;
		logic            periodicOrbitRefresh;
	} cfg_s;

	// receiver condition flags from the signal processing side
	typedef struct packed {
		logic fixValid;
		logic timeFixValid;
		logic signalGood;
		logic signalsInsufficient;
		logic anySignal;
		logic needMoreTime;
		logic fixLost;
		logic orbitDataLow;
		logic broadcastActive;
		logic downloadDone;
	} rx_status_s;
endpackage

// ==== rtl/ms_tick.sv ====
// millisecond tick divider
// assumes ref_clk runs CYCLES clocks per millisecond
module ms_tick #(
	parameter int CYCLES = gnss_pss_pkg::CYCLES_PER_MS
) (
	input  wire logic ref_clk,
	input  wire logic srst,
	output logic      msTick
);
	import gnss_pss_pkg::*;

	logic [31:0] divCount;

	if (CYCLES < 2) begin : g_chk
		$error("ms_tick needs at least two cycles per tick");
	end

	// one-cycle pulse at the end of each millisecond
	always_ff @(posedge ref_clk) begin
		if (srst || divCount == 32'(CYCLES - 1)) begin
			divCount <= '0;
		end else begin
			divCount <= divCount + 32'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		msTick <= !srst && divCount == 32'(CYCLES - 1);
	end
endmodule

// ==== rtl/ms_timer.sv ====
// reloadable millisecond down-counter
// assumes load is a one-cycle strobe; a zero load is expired at once
module ms_timer #(
	parameter int W = 32
) (
	input  wire logic         ref_clk,
	input  wire logic         srst,
	input  wire logic         load,
	input  wire logic [W-1:0] loadValue,
	input  wire logic         msTick,
	output logic              expired
);
	logic [W-1:0] remain;

	if (W < 2) begin : g_chk
		$error("ms_timer width too small");
	end

	// counts ticks down, stops at zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			remain <= '0;
		end else if (load) begin
			remain <= loadValue;
		end else if (msTick && remain != '0) begin
			remain <= remain - W'(1);
		end
	end

	assign expired = remain == '0;
endmodule

// ==== rtl/gnss_power_save_sequencer.sv ====
// power-save state sequencer: acquisition, tracking, power-optimised
// tracking and two inactive waits, timed on a millisecond grid
// assumes all inputs synchronous to ref_clk; times are ms into the week
//
// Behaviour
// - power-up starts in acquisition
// - fix in time tracks, else await search
// - hold timer starts on tracking entry
// - cyclic: hold expiry enters optimised tracking
// - optimised tracking keeps fixing; zero hold skips
// - weak or lost signal returns to tracking
// - re-enter only when good and hold expired
// - lost fix reacquires; failed acquisition awaits search
// - stay-awake never awaits search, ignores min
// - zero fix interval waits for wake
// - zero retry interval waits for wake
// - downloads run continuous during broadcast windows
// - orbit downloads on 30-minute grid or shortage
// - intervals follow absolute time grid
// - fix interval matters only in on/off
// - intervals over one week are refused
// - minimum search time, then fix or give up
// - hold time precedes optimised tracking or wait
// - time-fix hold adds at least two seconds
// - max search expiry awaits search; zero automatic
// - multi-system operation uses UTC grid
// - no signals gives up after 15 s
// - wake edges request fixes only when inactive
module gnss_power_save_sequencer #(
	parameter int CLK_PER_MS = gnss_pss_pkg::CYCLES_PER_MS
) (
	input  wire logic                     ref_clk,
	input  wire logic                     srst,
	input  wire logic                     cfgWrite,
	input  wire gnss_pss_pkg::cfg_s       cfgIn,
	input  wire gnss_pss_pkg::rx_status_s rxStatus,
	input  wire logic [31:0]              gpsWeekMs,
	input  wire logic [31:0]              utcWeekMs,
	input  wire logic                     multiGnss,
	input  wire logic                     externalWakeInput,
	input  wire logic                     rxLine,
	input  wire logic                     resetInputLow,
	output gnss_pss_pkg::seq_state_e      state,
	output gnss_pss_pkg::cfg_s            cfgActive,
	output logic                          fixEnable,
	output logic                          continuousDownload
);
	import gnss_pss_pkg::*;

	seq_state_e  next_state;
	logic        startPulse;
	logic        msTick;
	logic        extPrev;
	logic        rxPrev;
	logic        rstPrev;
	logic        wakeEvent;
	logic [31:0] gridTime;
	logic        fixGrid;
	logic        retryGrid;
	logic        orbitGrid;
	logic        downloadPending;
	logic        downloadHold;
	logic        fixSeen;
	logic        enterAcq;
	logic        enterTrack;
	logic        holdExpired;
	logic        minExpired;
	logic        maxExpired;
	logic        noSigExpired;
	logic        timeFixExpired;
	logic        minDone;
	logic        acqReady;
	logic        acqFail;
	logic        inactive;
	logic [31:0] maxLimit;

	// true on a tick when the absolute time sits on the period's grid
	function automatic logic gridHit(input logic [31:0] t,
					 input logic [31:0] period);
		gridHit = period != '0 && (t % period) == '0;
	endfunction

	if (CLK_PER_MS < 2) begin : g_chk
		$error("CLK_PER_MS must be at least two");
	end

	ms_tick #(.CYCLES(CLK_PER_MS)) u_tick (
		.ref_clk (ref_clk),
		.srst    (srst),
		.msTick  (msTick)
	);

	// host configuration; interval pair is taken only when both fit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfgActive <= '{MODE_CONTINUOUS, RST_FIX_INTERVAL,
				RST_RETRY_INTERVAL, RST_MIN_SEARCH,
				RST_MAX_SEARCH, RST_HOLD_TIME, 1'b0, 1'b0, 1'b0};
		end else if (cfgWrite) begin
			cfgActive.operatingModeSelect <= cfgIn.operatingModeSelect;
			cfgActive.minSearchTime <= cfgIn.minSearchTime;
			cfgActive.maxSearchTime <= cfgIn.maxSearchTime;
			cfgActive.trackingHoldTime <= cfgIn.trackingHoldTime;
			cfgActive.holdForTimeFix <= cfgIn.holdForTimeFix;
			cfgActive.stayAwakeOnNoFix <= cfgIn.stayAwakeOnNoFix;
			cfgActive.periodicOrbitRefresh <=
				cfgIn.periodicOrbitRefresh;
			if (cfgIn.fixInterval <= WEEK_MS &&
			    cfgIn.retryInterval <= WEEK_MS) begin
				cfgActive.fixInterval <= cfgIn.fixInterval;
				cfgActive.retryInterval <= cfgIn.retryInterval;
			end
		end
	end

	// one cycle after reset, loads acquisition timers and holds the fsm
	always_ff @(posedge ref_clk) begin
		startPulse <= srst;
	end

	// wake edge detectors; inputs are already synchronous
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			extPrev <= 1'b0;
			rxPrev  <= 1'b1;
			rstPrev <= 1'b1;
		end else begin
			extPrev <= externalWakeInput;
			rxPrev  <= rxLine;
			rstPrev <= resetInputLow;
		end
	end

	// any edge of the wake pin or receive line, rising edge of reset pin
	assign wakeEvent = (externalWakeInput ^ extPrev) |
		(rxLine ^ rxPrev) | (resetInputLow & ~rstPrev);

	// grid time base: utc when several systems run together
	assign gridTime  = multiGnss ? utcWeekMs : gpsWeekMs;
	assign fixGrid   = msTick &&
		gridHit(gridTime, cfgActive.fixInterval);
	assign retryGrid = msTick &&
		gridHit(gridTime, cfgActive.retryInterval);
	assign orbitGrid = msTick && cfgActive.periodicOrbitRefresh &&
		gridHit(gridTime, ORBIT_GRID_MS);

	// download request: grid point or too few satellites with orbits;
	// a new request in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			downloadPending <= 1'b0;
		end else if (orbitGrid || rxStatus.orbitDataLow) begin
			downloadPending <= 1'b1;
		end else if (rxStatus.downloadDone) begin
			downloadPending <= 1'b0;
		end
	end

	// continuous operation only while the wanted data is broadcast
	assign downloadHold = downloadPending && rxStatus.broadcastActive &&
		(state == ST_TRACK || state == ST_POT);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			continuousDownload <= 1'b0;
		end else begin
			continuousDownload <= downloadHold;
		end
	end

	// state entries reload the timers that they start
	assign enterAcq = startPulse ||
		(next_state == ST_ACQUIRE && state != ST_ACQUIRE);
	assign enterTrack =
		next_state == ST_TRACK && state != ST_TRACK;
	assign maxLimit = cfgActive.maxSearchTime == '0 ?
		AUTO_MAX_SEARCH_MS : cfgActive.maxSearchTime;

	ms_timer u_hold (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.load      (enterTrack),
		.loadValue (cfgActive.trackingHoldTime),
		.msTick    (msTick),
		.expired   (holdExpired)
	);

	ms_timer u_min (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.load      (enterAcq),
		.loadValue (cfgActive.minSearchTime),
		.msTick    (msTick),
		.expired   (minExpired)
	);

	ms_timer u_max (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.load      (enterAcq),
		.loadValue (maxLimit),
		.msTick    (msTick),
		.expired   (maxExpired)
	);

	// restarts whenever any signal is seen, so it measures silence
	ms_timer u_nosig (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.load      (enterAcq || rxStatus.anySignal),
		.loadValue (NO_SIGNAL_MS),
		.msTick    (msTick),
		.expired   (noSigExpired)
	);

	// extra wait counted from the first fix seen in acquisition
	ms_timer u_timefix (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.load      (state == ST_ACQUIRE && rxStatus.fixValid && !fixSeen),
		.loadValue (TIME_FIX_EXTRA_MS),
		.msTick    (msTick),
		.expired   (timeFixExpired)
	);

	always_ff @(posedge ref_clk) begin
		if (srst || enterAcq) begin
			fixSeen <= 1'b0;
		end else if (state == ST_ACQUIRE && rxStatus.fixValid) begin
			fixSeen <= 1'b1;
		end
	end

	// stay-awake ignores the minimum; device may prolong it
	assign minDone = cfgActive.stayAwakeOnNoFix ||
		(minExpired && !rxStatus.needMoreTime);
	assign acqReady = rxStatus.fixValid && minDone &&
		(!cfgActive.holdForTimeFix ||
		 (rxStatus.timeFixValid && fixSeen &&
		  timeFixExpired));
	assign acqFail = !cfgActive.stayAwakeOnNoFix &&
		cfgActive.operatingModeSelect != MODE_CONTINUOUS &&
		(maxExpired || noSigExpired ||
		 (minDone && rxStatus.signalsInsufficient));
	assign inactive = state == ST_WAIT_FIX || state == ST_WAIT_SEARCH;

	// next-state logic
	always_comb begin
		next_state = state;
		unique case (state)
			ST_ACQUIRE: begin
				if (startPulse) begin
					next_state = ST_ACQUIRE;
				end else if (acqReady) begin
					next_state = ST_TRACK;
				end else if (acqFail) begin
					next_state = ST_WAIT_SEARCH;
				end
			end
			ST_TRACK: begin
				if (rxStatus.fixLost) begin
					next_state = ST_ACQUIRE;
				end else if (holdExpired && !downloadHold) begin
					if (cfgActive.operatingModeSelect == MODE_CYCLIC &&
					    rxStatus.signalGood) begin
						next_state = ST_POT;
					end else if (cfgActive.operatingModeSelect ==
						     MODE_ON_OFF) begin
						next_state = ST_WAIT_FIX;
					end
				end
			end
			ST_POT: begin
				if (!rxStatus.signalGood || rxStatus.fixLost ||
				    downloadHold) begin
					next_state = ST_TRACK;
				end
			end
			ST_WAIT_FIX: begin
				// only on/off mode schedules on the fix grid
				if (wakeEvent || (fixGrid &&
				    cfgActive.operatingModeSelect ==
				    MODE_ON_OFF)) begin
					next_state = ST_ACQUIRE;
				end
			end
			ST_WAIT_SEARCH: begin
				if (wakeEvent || retryGrid) begin
					next_state = ST_ACQUIRE;
				end
			end
			default: next_state = ST_ACQUIRE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_ACQUIRE;
		end else begin
			state <= next_state;
		end
	end

	// fixes are produced at the navigation rate in both tracking states
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fixEnable <= 1'b0;
		end else begin
			fixEnable <= next_state == ST_TRACK ||
				next_state == ST_POT;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_acq_fail;
		state == ST_ACQUIRE && !startPulse && !acqReady && acqFail;
	endsequence

	sequence s_idle_no_wake(logic zeroPeriod);
		inactive && zeroPeriod && !wakeEvent;
	endsequence

	property p_power_up_acq;
		startPulse |-> state == ST_ACQUIRE && !fixEnable;
	endproperty
	a_power_up_acq: assert property (p_power_up_acq)
		else $error("sequencer did not start in acquisition");

	property p_hold_restart;
		(state == ST_TRACK && $past(state) != ST_TRACK &&
		 cfgActive.trackingHoldTime != '0 && !$past(cfgWrite))
		|-> !holdExpired;
	endproperty
	a_hold_restart: assert property (p_hold_restart)
		else $error("hold timer not restarted on tracking entry");

	property p_track_to_pot;
		(state == ST_TRACK && holdExpired && rxStatus.signalGood &&
		 !rxStatus.fixLost && !downloadHold &&
		 cfgActive.operatingModeSelect == MODE_CYCLIC)
		|=> state == ST_POT ##1 fixEnable;
	endproperty
	a_track_to_pot: assert property (p_track_to_pot)
		else $error("hold expiry did not enter optimised tracking");

	property p_pot_weak;
		(state == ST_POT && !rxStatus.signalGood)
		|=> state == ST_TRACK ##1 fixEnable;
	endproperty
	a_pot_weak: assert property (p_pot_weak)
		else $error("weak signal did not return to tracking");

	property p_stay_awake;
		(state == ST_ACQUIRE && cfgActive.stayAwakeOnNoFix)
		|=> state != ST_WAIT_SEARCH;
	endproperty
	a_stay_awake: assert property (p_stay_awake)
		else $error("stay-awake sequencer entered search wait");

	property p_fix_zero_wait;
		s_idle_no_wake(state == ST_WAIT_FIX &&
			cfgActive.fixInterval == '0) |=> state == ST_WAIT_FIX;
	endproperty
	a_fix_zero_wait: assert property (p_fix_zero_wait)
		else $error("zero fix interval left wait without wake");

	property p_retry_zero_wait;
		s_idle_no_wake(state == ST_WAIT_SEARCH &&
			cfgActive.retryInterval == '0) |=> state == ST_WAIT_SEARCH;
	endproperty
	a_retry_zero_wait: assert property (p_retry_zero_wait)
		else $error("zero retry interval left wait without wake");

	property p_reject_long;
		(cfgWrite && cfgIn.fixInterval > WEEK_MS)
		|=> cfgActive.fixInterval == $past(cfgActive.fixInterval) &&
		    cfgActive.retryInterval == $past(cfgActive.retryInterval);
	endproperty
	a_reject_long: assert property (p_reject_long)
		else $error("over-long interval was accepted");

	property p_acq_fail;
		s_acq_fail |=> state == ST_WAIT_SEARCH ##1 !fixEnable;
	endproperty
	a_acq_fail: assert property (p_acq_fail)
		else $error("failed acquisition did not await search");

	property p_wake_active;
		(!inactive && wakeEvent && !acqReady && !acqFail &&
		 !rxStatus.fixLost && state == ST_ACQUIRE && !startPulse)
		|=> state == ST_ACQUIRE;
	endproperty
	a_wake_active: assert property (p_wake_active)
		else $error("wake event disturbed an active state");

	property p_wake_restart;
		(inactive && wakeEvent) |=> state == ST_ACQUIRE;
	endproperty
	a_wake_restart: assert property (p_wake_restart)
		else $error("wake event did not restart acquisition");
endmodule

// ==== verif/host_model.sv ====
// host side model: absolute week time and wake pin edges
// assumes requests come one cycle long, launched by non-blocking assignment
module host_model #(
	parameter int CLK_PER_MS = 4
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        wakeReq,
	input  wire logic [1:0]  wakeKind,
	output logic [31:0]      gpsWeekMs,
	output logic [31:0]      utcWeekMs,
	output logic             externalWakeInput,
	output logic             rxLine,
	output logic             resetInputLow
);
	timeunit 1ns;
	timeprecision 1ps;
	int divCnt = 0;

	// week time steps each millisecond; utc offset exposes the grid source
	always @(negedge ref_clk) begin
		if (srst) begin
			divCnt <= 0;
			gpsWeekMs <= 32'h00000000;
		end else if (divCnt == CLK_PER_MS - 1) begin
			divCnt <= 0;
			gpsWeekMs <= gpsWeekMs + 32'h00000001;
		end else begin
			divCnt <= divCnt + 1;
		end
	end
	assign utcWeekMs = gpsWeekMs + 32'h00000003;

	// one edge per request; the reset pin drops and rises one cycle later
	always @(negedge ref_clk) begin
		if (srst) begin
			externalWakeInput <= 1'b0;
			rxLine <= 1'b1;
			resetInputLow <= 1'b1;
		end else if (wakeReq) begin
			case (wakeKind)
				2'h0: externalWakeInput <= !externalWakeInput;
				2'h1: rxLine <= !rxLine;
				default: resetInputLow <= 1'b0;
			endcase
		end else begin
			resetInputLow <= 1'b1;
		end
	end
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the power-save sequencer
// assumes a ms tick of 4 clocks; state changes are noted in a queue
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gnss_pss_pkg::*;
	localparam int MS = 4;
	logic ref_clk, srst, cfgWrite, wakeReq, fixEnable, continuousDownload;
	logic [1:0] wakeKind;
	logic [31:0] gpsWeekMs, utcWeekMs, r;
	logic extWake, rxLine, resetInputLow, multiGnss;
	cfg_s cfgIn, cfg, cfgActive;
	rx_status_s rx;
	seq_state_e state, lastSt;
	seq_state_e expQ[$];
	int n_errors = 0;
	int compares = 0;

	gnss_power_save_sequencer #(.CLK_PER_MS(MS)) i_gnss_power_save_sequencer (
		.ref_clk(ref_clk), .srst(srst), .cfgWrite(cfgWrite), .cfgIn(cfgIn),
		.rxStatus(rx), .gpsWeekMs(gpsWeekMs), .utcWeekMs(utcWeekMs),
		.multiGnss(multiGnss), .externalWakeInput(extWake), .rxLine(rxLine),
		.resetInputLow(resetInputLow), .state(state), .cfgActive(cfgActive),
		.fixEnable(fixEnable), .continuousDownload(continuousDownload));
	host_model #(.CLK_PER_MS(MS)) i_host_model (
		.ref_clk(ref_clk), .srst(srst), .wakeReq(wakeReq),
		.wakeKind(wakeKind), .gpsWeekMs(gpsWeekMs), .utcWeekMs(utcWeekMs),
		.externalWakeInput(extWake), .rxLine(rxLine),
		.resetInputLow(resetInputLow));

	task automatic stop_test();
		$display("checks %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check_state(input string nm, input seq_state_e e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic check_val(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic check_range(input string nm, input int v, lo, hi);
		compares++;
		if (v < lo || v > hi) begin
			n_errors++;
			$display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, v);
		end
	endtask
	// note the next state, then time its arrival in ms bounds
	task automatic expect_to(input seq_state_e st, input int lo, hi);
		int n;
		n = 0;
		expQ.push_back(st);
		while (state !== st && n <= hi * MS) begin
			@(negedge ref_clk);
			n++;
		end
		check_range("cycles to state", n, lo * MS, hi * MS);
	endtask
	task automatic write_cfg();
		cfgIn = cfg;
		cfgWrite = 1'b1;
		@(negedge ref_clk);
		cfgWrite = 1'b0;
		@(negedge ref_clk);
	endtask
	// non-blocking so the model samples the request a cycle later
	task automatic wake(input logic [1:0] k);
		wakeKind <= k;
		wakeReq <= 1'b1;
		@(negedge ref_clk);
		wakeReq <= 1'b0;
	endtask
	task automatic idle(input int ms);
		repeat (ms * MS) @(negedge ref_clk);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// watcher: every state change takes the oldest note, none means held
	always @(negedge ref_clk) begin
		if (srst)
			lastSt = state;
		else if (state !== lastSt) begin
			if (expQ.size() == 0)
				check_state("state held", lastSt, state);
			else
				check_state("state order", expQ.pop_front(), state);
			lastSt = state;
		end
	end
	// watchdog about a sixth beyond the planned run
	initial begin
		repeat (80000) @(negedge ref_clk);
		n_errors++;
		stop_test();
	end

	initial begin
		srst = 1'b1;
		cfgWrite = 1'b0;
		wakeReq = 1'b0;
		wakeKind = 2'h0;
		multiGnss = 1'b0;
		cfg = '0;
		cfgIn = '0;
		rx = '0;
		rx.anySignal = 1'b1;
		rx.signalGood = 1'b1;
		void'($urandom(86539));
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		check_state("state after reset", ST_ACQUIRE, state);
		cfg.operatingModeSelect = MODE_CYCLIC;
		cfg.maxSearchTime = 32'h00000014;
		cfg.trackingHoldTime = 32'h0000000a;
		write_cfg();
		check_val("max search", 32'h00000014, cfgActive.maxSearchTime);
		rx.signalsInsufficient = 1'b1;
		expect_to(ST_WAIT_SEARCH, 0, 2);
		idle(30);
		rx.signalsInsufficient = 1'b0;
		wake(2'h1);
		expect_to(ST_ACQUIRE, 0, 1);
		expect_to(ST_WAIT_SEARCH, 19, 22);
		wake(2'h2);
		expect_to(ST_ACQUIRE, 0, 1);
		idle(2);
		rx.fixValid = 1'b1;
		expect_to(ST_TRACK, 0, 1);
		check_val("fixEnable", 32'h1, 32'(fixEnable));
		expect_to(ST_POT, 9, 12);
		wake(2'h0);
		idle(4);
		check_val("fixEnable pot", 32'h1, 32'(fixEnable));
		rx.signalGood = 1'b0;
		expect_to(ST_TRACK, 0, 1);
		idle(3);
		rx.signalGood = 1'b1;
		expect_to(ST_POT, 6, 9);
		rx.orbitDataLow = 1'b1;
		rx.broadcastActive = 1'b1;
		expect_to(ST_TRACK, 0, 1);
		@(negedge ref_clk);
		check_val("download", 32'h1, 32'(continuousDownload));
		rx.orbitDataLow = 1'b0;
		rx.downloadDone = 1'b1;
		@(negedge ref_clk);
		rx.downloadDone = 1'b0;
		repeat (3) @(negedge ref_clk);
		check_val("download off", 32'h0, 32'(continuousDownload));
		rx.broadcastActive = 1'b0;
		expect_to(ST_POT, 0, 12);
		cfg.trackingHoldTime = 32'h00000000;
		write_cfg();
		rx.signalGood = 1'b0;
		expect_to(ST_TRACK, 0, 1);
		rx.signalGood = 1'b1;
		expect_to(ST_POT, 0, 1);
		rx.fixLost = 1'b1;
		rx.fixValid = 1'b0;
		expect_to(ST_TRACK, 0, 1);
		expect_to(ST_ACQUIRE, 0, 1);
		rx.fixLost = 1'b0;
		expect_to(ST_WAIT_SEARCH, 18, 22);
		cfg.stayAwakeOnNoFix = 1'b1;
		write_cfg();
		rx.signalsInsufficient = 1'b1;
		wake(2'h1);
		expect_to(ST_ACQUIRE, 0, 1);
		wake(2'h0);
		idle(30);
		cfg.fixInterval = WEEK_MS + 32'h00000001;
		cfg.trackingHoldTime = 32'h00000007;
		write_cfg();
		check_val("fix kept", 32'h0, cfgActive.fixInterval);
		check_val("retry kept", 32'h0, cfgActive.retryInterval);
		check_val("hold taken", 32'h7, cfgActive.trackingHoldTime);
		r = $urandom % WEEK_MS;
		cfg.fixInterval = r;
		cfg.retryInterval = WEEK_MS;
		write_cfg();
		check_val("fix taken", r, cfgActive.fixInterval);
		check_val("retry week", WEEK_MS, cfgActive.retryInterval);
		rx.signalsInsufficient = 1'b0;
		rx.fixValid = 1'b1;
		expect_to(ST_TRACK, 0, 1);
		cfg = '0;
		multiGnss = 1'b1;
		cfg.operatingModeSelect = MODE_ON_OFF;
		cfg.trackingHoldTime = 32'h00000005;
		write_cfg();
		expect_to(ST_WAIT_FIX, 4, 9);
		idle(20);
		wake(2'h2);
		expect_to(ST_ACQUIRE, 0, 1);
		expect_to(ST_TRACK, 0, 1);
		cfg.fixInterval = 32'h00000008;
		write_cfg();
		expect_to(ST_WAIT_FIX, 3, 7);
		expect_to(ST_ACQUIRE, 0, 9);
		check_val("utc grid", 32'h0, utcWeekMs & 32'h00000006);
		expect_to(ST_TRACK, 0, 1);
		// silent sky: the no-signal limit ends the search before the max
		rx.fixLost = 1'b1;
		rx.fixValid = 1'b0;
		rx.anySignal = 1'b0;
		expect_to(ST_ACQUIRE, 0, 1);
		rx.fixLost = 1'b0;
		expect_to(ST_WAIT_SEARCH, 14999, 15001);
		// time-fix hold: tracking waits two seconds past the first fix
		cfg.holdForTimeFix = 1'b1;
		write_cfg();
		rx.anySignal = 1'b1;
		rx.fixValid = 1'b1;
		rx.timeFixValid = 1'b1;
		wake(2'h1);
		expect_to(ST_ACQUIRE, 0, 1);
		expect_to(ST_TRACK, 1999, 2002);
		stop_test();
	end
endmodule
